//--- ssrp_pkg.sv
// Package of constants and types for the status and service request block.
package ssrp_pkg;
  localparam int STB_W = 8;
  localparam int EVT_W = 16;
  localparam int ERR_CODE_W = 16;
  localparam int ERR_DEPTH = 8;
  localparam int ERR_PTR_W = 3;
  localparam int ERR_CNT_W = 4;
  localparam int OBUF_CNT_W = 8;
  localparam int PPOLL_LINE_W = 3;
  localparam logic [ERR_CODE_W-1:0] ERR_NONE_CODE = 16'h0000;
  localparam logic [STB_W-1:0] STB_SRQ_MASK = 8'hbe;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_EAV_BIT = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_OPER_BIT = 7;
  localparam int STB_XQUES_BIT = 1;
  localparam int STB_RQS_BIT = 6;
  localparam int ESR_OPC_BIT = 0;
  localparam logic [STB_W-1:0] SRE_RESET = 8'h00;
  localparam logic [STB_W-1:0] ESE_RESET = 8'h00;
  localparam logic [STB_W-1:0] PPE_RESET = 8'h00;
  localparam logic [EVT_W-1:0] EVT_ENA_RESET = 16'h0000;
  localparam logic [EVT_W-1:0] PTR_RESET = 16'hffff;
  localparam logic [EVT_W-1:0] NTR_RESET = 16'h0000;
  localparam int NUM_SREG = 3;
  localparam int SREG_OPER = 0;
  localparam int SREG_QUES = 1;
  localparam int SREG_XQUES = 2;
  typedef enum logic [2:0] {
    SSRP_RD_STB,
    SSRP_RD_ESR,
    SSRP_RD_EVT,
    SSRP_RD_COND,
    SSRP_RD_IST,
    SSRP_RD_ERR
  } ssrp_rd_type;
endpackage

//--- ssrp_status.sv
// Status byte, event registers, error queue and poll answers of the device.
//
// Functional notes
// - Raise service request when an enabled status byte bit 1,2,3,4,5 or 7 is set.
// - Each such status byte bit summarises a register, error queue or output buffer.
// - Standard event enable bit 0 selects operation complete into the event summary.
// - Service request enable bit 5 maps to the event status summary bit.
// - Device never starts bus activity except asserting service request.
// - Serial poll returns the status byte, same as the status byte query.
// - Parallel poll ANDs enable with status byte including bit 6, ORs, optional invert.
// - Device drives its assigned data line during a parallel poll.
// - Poll line and invert settings are configured first and then retained.
// - Combined parallel poll bit is readable without a parallel poll.
// - Register queries return a number equal to the register bit pattern.
// - Each detected error pushes one entry unless the queue is full; each error query pops one entry, none when empty.
// - Empty error queue query returns code 0, meaning no error.
// - Device clear, reset and system preset leave the status system unchanged.
// - Clear status clears status byte, events and error queue, not enables.
// - Device clear flushes output buffer and aborts command processing and input.
// - First command of a new program message discards pending output.
// - Reset and system preset restore settings but leave status system alone.
// - Reading the standard event register clears it.
// - Reading any event part clears that event part.
`timescale 1ns/100ps
module ssrp_status
  import ssrp_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [STB_W-1:0] ESR_SET,
  input wire logic OP_COMPLETE,
  input wire logic [NUM_SREG*EVT_W-1:0] COND_IN,
  input wire logic OBUF_PUSH,
  input wire logic OBUF_POP,
  input wire logic ERR_PUSH,
  input wire logic [ERR_CODE_W-1:0] ERR_CODE_IN,
  input wire logic SRE_WR,
  input wire logic ESE_WR,
  input wire logic PPE_WR,
  input wire logic [STB_W-1:0] WR_DATA,
  input wire logic [NUM_SREG-1:0] EVT_ENA_WR,
  input wire logic [NUM_SREG-1:0] PTR_WR,
  input wire logic [NUM_SREG-1:0] NTR_WR,
  input wire logic [EVT_W-1:0] EVT_WR_DATA,
  input wire logic RD_REQ,
  input wire ssrp_rd_type RD_SEL,
  input wire logic [1:0] RD_IDX,
  input wire logic CMD_CLS,
  input wire logic CMD_STAT_PRESET,
  input wire logic CMD_RST,
  input wire logic CMD_DCL,
  input wire logic MSG_FIRST_CMD,
  input wire logic PPC_WR,
  input wire logic [PPOLL_LINE_W-1:0] PPC_LINE,
  input wire logic PPC_SENSE,
  input wire logic SPOLL_REQ,
  input wire logic PPOLL_REQ,
  output logic SRQ,
  output logic [EVT_W-1:0] RD_DATA,
  output logic RD_VALID,
  output logic [STB_W-1:0] SPOLL_DATA,
  output logic SPOLL_VALID,
  output logic [STB_W-1:0] PP_DATA_O,
  output logic [STB_W-1:0] PP_DATA_OE,
  output logic SETTINGS_DEFAULT,
  output logic CMD_ABORT,
  output logic IBUF_FLUSH,
  output logic [OBUF_CNT_W-1:0] OBUF_LEVEL,
  output logic [ERR_CNT_W-1:0] ERR_COUNT
);

  logic [STB_W-1:0] sre_q;
  logic [STB_W-1:0] ese_q;
  logic [STB_W-1:0] ppe_q;
  logic [STB_W-1:0] esr_q;
  logic [EVT_W-1:0] evt_q [NUM_SREG];
  logic [EVT_W-1:0] ena_q [NUM_SREG];
  logic [EVT_W-1:0] ptr_q [NUM_SREG];
  logic [EVT_W-1:0] ntr_q [NUM_SREG];
  logic [EVT_W-1:0] cond_q [NUM_SREG];
  logic [NUM_SREG-1:0] summ;
  logic [ERR_CODE_W-1:0] errq_mem [ERR_DEPTH];
  logic [ERR_PTR_W-1:0] err_wr_q;
  logic [ERR_PTR_W-1:0] err_rd_q;
  logic [ERR_CNT_W-1:0] err_cnt_q;
  logic [OBUF_CNT_W-1:0] obuf_q;
  logic [PPOLL_LINE_W-1:0] pp_line_q;
  logic pp_sense_q;
  logic [STB_W-1:0] stb;
  logic ist;
  logic rd_esr;
  logic rd_err;
  logic err_pop;
  logic err_full;
  logic [NUM_SREG-1:0] rd_evt;

  assign rd_esr = RD_REQ && (RD_SEL == SSRP_RD_ESR);
  assign rd_err = RD_REQ && (RD_SEL == SSRP_RD_ERR);
  assign err_pop = rd_err && (err_cnt_q != '0);
  assign err_full = (err_cnt_q == ERR_CNT_W'(ERR_DEPTH));

  // Status byte bits summarise lower registers, the queue and output.
  always_comb begin
    stb = '0;
    stb[STB_XQUES_BIT] = summ[SREG_XQUES];
    stb[STB_EAV_BIT] = (err_cnt_q != '0);
    stb[STB_QUES_BIT] = summ[SREG_QUES];
    stb[STB_MAV_BIT] = (obuf_q != '0);
    stb[STB_ESB_BIT] = |(esr_q & ese_q);
    stb[STB_OPER_BIT] = summ[SREG_OPER];
    stb[STB_RQS_BIT] = |(stb & sre_q & STB_SRQ_MASK);
  end

  // Parallel poll bit includes bit 6 of the status byte.
  assign ist = |(ppe_q & stb);

  // The service request line is the only thing this block raises alone.
  assign SRQ = stb[STB_RQS_BIT];

  // Enable registers survive clear status, device clear and reset.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sre_q <= SRE_RESET;
      ese_q <= ESE_RESET;
      ppe_q <= PPE_RESET;
    end else begin
      if (SRE_WR) begin
        sre_q <= WR_DATA;
      end
      if (ESE_WR) begin
        ese_q <= WR_DATA;
      end
      if (PPE_WR) begin
        ppe_q <= WR_DATA;
      end
    end
  end

  // Standard events; a new event wins over a clearing read.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      esr_q <= '0;
    end else begin
      if (rd_esr || CMD_CLS) begin
        esr_q <= ESR_SET;
      end else begin
        esr_q <= esr_q | ESR_SET;
      end
      if (OP_COMPLETE) begin
        esr_q[ESR_OPC_BIT] <= 1'b1;
      end
    end
  end

  // One set of condition, transition, event and enable parts per register.
  genvar g;
  generate
    for (g = 0; g < NUM_SREG; g++) begin : g_sreg
      logic [EVT_W-1:0] cond_now;
      logic [EVT_W-1:0] edges;
      assign cond_now = COND_IN[g*EVT_W +: EVT_W];
      assign edges = (cond_now & ~cond_q[g] & ptr_q[g]) |
                     (~cond_now & cond_q[g] & ntr_q[g]);
      assign summ[g] = |(evt_q[g] & ena_q[g]);
      assign rd_evt[g] = RD_REQ && (RD_SEL == SSRP_RD_EVT) &&
                         (RD_IDX == 2'(g));
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          cond_q[g] <= '0;
          evt_q[g] <= '0;
        end else begin
          cond_q[g] <= cond_now;
          if (rd_evt[g] || CMD_CLS) begin
            evt_q[g] <= edges;
          end else begin
            evt_q[g] <= evt_q[g] | edges;
          end
        end
      end
      // Status preset touches only enables and transition filters.
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          ena_q[g] <= EVT_ENA_RESET;
          ptr_q[g] <= PTR_RESET;
          ntr_q[g] <= NTR_RESET;
        end else if (CMD_STAT_PRESET) begin
          ena_q[g] <= EVT_ENA_RESET;
          ptr_q[g] <= PTR_RESET;
          ntr_q[g] <= NTR_RESET;
        end else begin
          if (EVT_ENA_WR[g]) begin
            ena_q[g] <= EVT_WR_DATA;
          end
          if (PTR_WR[g]) begin
            ptr_q[g] <= EVT_WR_DATA;
          end
          if (NTR_WR[g]) begin
            ntr_q[g] <= EVT_WR_DATA;
          end
        end
      end
    end
  endgenerate

  // Error queue; when full the newest error is dropped to keep older causes.
  always_ff @(posedge CLK_SYS) begin
    if (ERR_PUSH && !err_full && !CMD_CLS) begin
      errq_mem[err_wr_q] <= ERR_CODE_IN;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      err_wr_q <= '0;
      err_rd_q <= '0;
      err_cnt_q <= '0;
    end else if (CMD_CLS) begin
      err_wr_q <= '0;
      err_rd_q <= '0;
      err_cnt_q <= '0;
    end else begin
      if (ERR_PUSH && !err_full) begin
        err_wr_q <= err_wr_q + 1'b1;
      end
      if (err_pop) begin
        err_rd_q <= err_rd_q + 1'b1;
      end
      if ((ERR_PUSH && !err_full) && !err_pop) begin
        err_cnt_q <= err_cnt_q + 1'b1;
      end else if (!(ERR_PUSH && !err_full) && err_pop) begin
        err_cnt_q <= err_cnt_q - 1'b1;
      end
    end
  end

  // Output buffer level; flushed by device clear and new messages.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      obuf_q <= '0;
    end else if (CMD_DCL || MSG_FIRST_CMD) begin
      obuf_q <= '0;
    end else if (OBUF_PUSH && !OBUF_POP && obuf_q != '1) begin
      obuf_q <= obuf_q + 1'b1;
    end else if (OBUF_POP && !OBUF_PUSH && obuf_q != '0) begin
      obuf_q <= obuf_q - 1'b1;
    end
  end

  // Abort pulses go out one cycle after device clear; settings only on reset.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CMD_ABORT <= 1'b0;
      IBUF_FLUSH <= 1'b0;
      SETTINGS_DEFAULT <= 1'b0;
    end else begin
      CMD_ABORT <= CMD_DCL;
      IBUF_FLUSH <= CMD_DCL;
      SETTINGS_DEFAULT <= CMD_RST;
    end
  end

  // Query answers come one cycle after the request.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RD_DATA <= '0;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_REQ;
      if (RD_REQ) begin
        unique case (RD_SEL)
          SSRP_RD_STB: RD_DATA <= EVT_W'(stb);
          SSRP_RD_ESR: RD_DATA <= EVT_W'(esr_q);
          SSRP_RD_EVT: RD_DATA <= (RD_IDX < 2'(NUM_SREG)) ?
                                  evt_q[RD_IDX] : '0;
          SSRP_RD_COND: RD_DATA <= (RD_IDX < 2'(NUM_SREG)) ?
                                   cond_q[RD_IDX] : '0;
          SSRP_RD_IST: RD_DATA <= EVT_W'(ist);
          SSRP_RD_ERR: RD_DATA <= err_pop ? errq_mem[err_rd_q] :
                                  ERR_NONE_CODE;
          default: RD_DATA <= '0;
        endcase
      end
    end
  end

  // Serial poll answer matches the status byte query.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SPOLL_DATA <= '0;
      SPOLL_VALID <= 1'b0;
    end else begin
      SPOLL_VALID <= SPOLL_REQ;
      if (SPOLL_REQ) begin
        SPOLL_DATA <= stb;
      end
    end
  end

  // Line and sense are kept until reconfigured.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pp_line_q <= '0;
      pp_sense_q <= 1'b0;
    end else if (PPC_WR) begin
      pp_line_q <= PPC_LINE;
      pp_sense_q <= PPC_SENSE;
    end
  end

  // Drive only the assigned line, and only while the poll lasts.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PP_DATA_O <= '0;
      PP_DATA_OE <= '0;
    end else begin
      PP_DATA_O <= '0;
      PP_DATA_OE <= '0;
      if (PPOLL_REQ) begin
        PP_DATA_O[pp_line_q] <= ist ^ pp_sense_q;
        PP_DATA_OE[pp_line_q] <= 1'b1;
      end
    end
  end

  assign OBUF_LEVEL = obuf_q;
  assign ERR_COUNT = err_cnt_q;

endmodule

//--- ssrp_status_properties.sv
// Port checker of the status and service request block.
`timescale 1ns/100ps
module ssrp_status_props
  import ssrp_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic ERR_PUSH,
  input wire logic OBUF_PUSH,
  input wire logic SRE_WR,
  input wire logic [STB_W-1:0] WR_DATA,
  input wire logic RD_REQ,
  input wire ssrp_rd_type RD_SEL,
  input wire logic CMD_CLS,
  input wire logic CMD_DCL,
  input wire logic PPC_WR,
  input wire logic [PPOLL_LINE_W-1:0] PPC_LINE,
  input wire logic PPOLL_REQ,
  input wire logic SRQ,
  input wire logic [EVT_W-1:0] RD_DATA,
  input wire logic RD_VALID,
  input wire logic [STB_W-1:0] PP_DATA_OE,
  input wire logic CMD_ABORT,
  input wire logic IBUF_FLUSH,
  input wire logic [OBUF_CNT_W-1:0] OBUF_LEVEL,
  input wire logic [ERR_CNT_W-1:0] ERR_COUNT
);
  logic [STB_W-1:0] sre_q;
  logic [PPOLL_LINE_W-1:0] ppl_q;
  // Shadows of the enable and line settings, kept only from port writes.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sre_q <= SRE_RESET;
      ppl_q <= 3'h0;
    end else begin
      sre_q <= SRE_WR ? WR_DATA : sre_q;
      ppl_q <= PPC_WR ? PPC_LINE : ppl_q;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_err_rd;
    RD_REQ && RD_SEL == SSRP_RD_ERR && !ERR_PUSH && !CMD_CLS;
  endsequence
  sequence s_pp_poll;
    PPC_WR ##1 (PPOLL_REQ && !PPC_WR);
  endsequence
  a_srq_err: assert property (
    sre_q[STB_EAV_BIT] && ERR_COUNT != 4'h0 |-> SRQ)
    else $error("no service request for error");
  a_srq_none: assert property (sre_q == 8'h00 |-> !SRQ)
    else $error("service request without enable");
  a_rd_answer: assert property (RD_REQ |=> RD_VALID)
    else $error("read not answered");
  a_pp_line: assert property (
    s_pp_poll |=> PP_DATA_OE == 8'h01 << ppl_q)
    else $error("wrong poll line");
  a_pp_quiet: assert property (!PPOLL_REQ |=> PP_DATA_OE == 8'h00)
    else $error("data line driven unasked");
  a_err_pop: assert property (
    s_err_rd ##0 ERR_COUNT != 4'h0 |=>
    ERR_COUNT == $past(ERR_COUNT) - 4'h1)
    else $error("bad pop");
  a_err_empty: assert property (
    s_err_rd ##0 ERR_COUNT == 4'h0 |=> RD_DATA == ERR_NONE_CODE)
    else $error("bad empty code");
  a_cls_clear: assert property (CMD_CLS |=> ERR_COUNT == 4'h0)
    else $error("queue kept");
  a_dcl_flush: assert property (
    CMD_DCL && !OBUF_PUSH |=>
    OBUF_LEVEL == 8'h00 && CMD_ABORT && IBUF_FLUSH)
    else $error("clear incomplete");
endmodule
bind ssrp_status ssrp_status_props u_props (
  .CLK_SYS(CLK_SYS), .RST(RST), .ERR_PUSH(ERR_PUSH), .OBUF_PUSH(OBUF_PUSH),
  .SRE_WR(SRE_WR), .WR_DATA(WR_DATA), .RD_REQ(RD_REQ), .RD_SEL(RD_SEL),
  .CMD_CLS(CMD_CLS), .CMD_DCL(CMD_DCL), .PPC_WR(PPC_WR),
  .PPC_LINE(PPC_LINE), .PPOLL_REQ(PPOLL_REQ), .SRQ(SRQ),
  .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .PP_DATA_OE(PP_DATA_OE),
  .CMD_ABORT(CMD_ABORT), .IBUF_FLUSH(IBUF_FLUSH),
  .OBUF_LEVEL(OBUF_LEVEL), .ERR_COUNT(ERR_COUNT)
);

//--- ssrp_ctrl_model.sv
// Bus controller side of the parallel poll data lines.
`timescale 1ns/100ps
module ssrp_ctrl_model
  import ssrp_pkg::*;
(
  input wire logic [STB_W-1:0] PP_DATA_O,
  input wire logic [STB_W-1:0] PP_DATA_OE,
  output logic [STB_W-1:0] DIO
);
  // Released lines sit at the pull-up level, never at a stale value.
  always_comb begin
    for (int i = 0; i < STB_W; i++) begin
      DIO[i] = PP_DATA_OE[i] ? PP_DATA_O[i] : 1'b1;
    end
  end
endmodule

//--- ssrp_status_tb_top.sv
// Self-checking bench of the status and service request block.
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module ssrp_status_tb_top
  import ssrp_pkg::*;
;
  logic CLK_SYS, RST, SRE_WR, ESE_WR, PPE_WR, RD_REQ, PPC_WR, PPC_SENSE;
  logic OP_COMPLETE, OBUF_PUSH, OBUF_POP, ERR_PUSH, CMD_CLS, CMD_STAT_PRESET;
  logic CMD_RST, CMD_DCL, MSG_FIRST_CMD, SPOLL_REQ, PPOLL_REQ, SRQ, RD_VALID;
  logic SPOLL_VALID, SETTINGS_DEFAULT, CMD_ABORT, IBUF_FLUSH;
  logic [7:0] ESR_SET, WR_DATA, SPOLL_DATA, PP_DATA_O, PP_DATA_OE, OBUF_LEVEL;
  logic [7:0] DIO;
  logic [47:0] COND_IN;
  logic [2:0] EVT_ENA_WR, PTR_WR, NTR_WR, PPC_LINE;
  logic [15:0] ERR_CODE_IN, EVT_WR_DATA, RD_DATA, got, e;
  logic [15:0] exp_q[$];
  logic [15:0] c[3];
  logic [3:0] ERR_COUNT;
  logic [1:0] RD_IDX;
  logic [10:0] pv;
  ssrp_rd_type RD_SEL;
  int n_mismatch, checked;
  assign {PPOLL_REQ, SPOLL_REQ, OBUF_POP, MSG_FIRST_CMD, CMD_DCL, CMD_RST,
    CMD_STAT_PRESET, CMD_CLS, ERR_PUSH, OBUF_PUSH, OP_COMPLETE} = pv;
  ssrp_status uut (
    .CLK_SYS(CLK_SYS), .RST(RST), .ESR_SET(ESR_SET),
    .OP_COMPLETE(OP_COMPLETE), .COND_IN(COND_IN), .OBUF_PUSH(OBUF_PUSH),
    .OBUF_POP(OBUF_POP), .ERR_PUSH(ERR_PUSH), .ERR_CODE_IN(ERR_CODE_IN),
    .SRE_WR(SRE_WR), .ESE_WR(ESE_WR), .PPE_WR(PPE_WR), .WR_DATA(WR_DATA),
    .EVT_ENA_WR(EVT_ENA_WR), .PTR_WR(PTR_WR), .NTR_WR(NTR_WR),
    .EVT_WR_DATA(EVT_WR_DATA), .RD_REQ(RD_REQ), .RD_SEL(RD_SEL),
    .RD_IDX(RD_IDX), .CMD_CLS(CMD_CLS), .CMD_STAT_PRESET(CMD_STAT_PRESET),
    .CMD_RST(CMD_RST), .CMD_DCL(CMD_DCL), .MSG_FIRST_CMD(MSG_FIRST_CMD),
    .PPC_WR(PPC_WR), .PPC_LINE(PPC_LINE), .PPC_SENSE(PPC_SENSE),
    .SPOLL_REQ(SPOLL_REQ), .PPOLL_REQ(PPOLL_REQ), .SRQ(SRQ),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .SPOLL_DATA(SPOLL_DATA),
    .SPOLL_VALID(SPOLL_VALID), .PP_DATA_O(PP_DATA_O),
    .PP_DATA_OE(PP_DATA_OE), .SETTINGS_DEFAULT(SETTINGS_DEFAULT),
    .CMD_ABORT(CMD_ABORT), .IBUF_FLUSH(IBUF_FLUSH),
    .OBUF_LEVEL(OBUF_LEVEL), .ERR_COUNT(ERR_COUNT)
  );
  ssrp_ctrl_model ctrl (.PP_DATA_O(PP_DATA_O), .PP_DATA_OE(PP_DATA_OE),
    .DIO(DIO));
  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  task automatic pls(input logic [10:0] m);
    @(posedge CLK_SYS);
    pv <= m;
    @(posedge CLK_SYS);
    pv <= 11'h000;
    @(negedge CLK_SYS);
  endtask
  task automatic wr(input logic [2:0] k, input logic [7:0] d);
    @(posedge CLK_SYS);
    WR_DATA <= d;
    {PPE_WR, ESE_WR, SRE_WR} <= k;
    @(posedge CLK_SYS);
    {PPE_WR, ESE_WR, SRE_WR} <= 3'h0;
    @(negedge CLK_SYS);
  endtask
  task automatic rd(input ssrp_rd_type s, input logic [15:0] x);
    exp_q.push_back(x);
    @(posedge CLK_SYS);
    RD_SEL <= s;
    RD_REQ <= 1'b1;
    @(posedge CLK_SYS);
    RD_REQ <= 1'b0;
    @(negedge CLK_SYS);
  endtask
  task automatic end_of_test();
    // A request whose answer never came counts as a mismatch.
    if (exp_q.size() != 0) begin
      n_mismatch++;
    end
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Every read, serial poll or poll answer takes the oldest expectation.
  always @(negedge CLK_SYS) begin
    if (RD_VALID === 1'b1 || SPOLL_VALID === 1'b1 ||
        |PP_DATA_OE === 1'b1) begin
      got = RD_VALID === 1'b1 ? RD_DATA : {8'h00, SPOLL_VALID === 1'b1 ?
        SPOLL_DATA : DIO};
      // An answer that nobody asked for must not pass silently.
      if (exp_q.size() == 0) begin
        e = ~got;
      end else begin
        e = exp_q.pop_front();
      end
      `CHK(got, e)
    end
  end
  // The tests need under 700 cycles, so 4000 cycles means a hang.
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    RST = 1'b1;
    {pv, SRE_WR, ESE_WR, PPE_WR, RD_REQ, PPC_WR, PPC_SENSE, RD_IDX} = '0;
    {ESR_SET, WR_DATA, COND_IN, EVT_ENA_WR, PTR_WR, NTR_WR, PPC_LINE} = '0;
    {ERR_CODE_IN, EVT_WR_DATA} = '0;
    RD_SEL = SSRP_RD_STB;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'hdec80fb7));
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    wr(3'h2, 8'h01);
    wr(3'h1, 8'h20);
    pls(11'h001);
    `CHK(SRQ, 1'b1)
    exp_q.push_back(16'h0060);
    pls(11'h200);
    rd(SSRP_RD_STB, 16'h0060);
    rd(SSRP_RD_ESR, 16'h0001);
    rd(SSRP_RD_ESR, 16'h0000);
    `CHK(SRQ, 1'b0)
    $display("test 1 done");
    wr(3'h1, 8'h04);
    for (int i = 0; i < 3; i++) begin
      c[i] = 16'($urandom) | 16'h0001;
      @(posedge CLK_SYS);
      ERR_CODE_IN <= c[i];
      pls(11'h004);
    end
    `CHK(ERR_COUNT, 4'h3)
    `CHK(SRQ, 1'b1)
    for (int i = 0; i < 3; i++) rd(SSRP_RD_ERR, c[i]);
    rd(SSRP_RD_ERR, ERR_NONE_CODE);
    `CHK(SRQ, 1'b0)
    $display("test 2 done");
    wr(3'h1, 8'h30);
    repeat (9) pls(11'h004);
    `CHK(ERR_COUNT, 4'h8)
    pls(11'h002);
    pls(11'h002);
    pls(11'h100);
    `CHK(OBUF_LEVEL, 8'h01)
    `CHK(SRQ, 1'b1)
    pls(11'h070);
    `CHK(SETTINGS_DEFAULT, 1'b1)
    `CHK(CMD_ABORT, 1'b1)
    `CHK(IBUF_FLUSH, 1'b1)
    `CHK(ERR_COUNT, 4'h8)
    `CHK(OBUF_LEVEL, 8'h00)
    pls(11'h002);
    pls(11'h080);
    `CHK(OBUF_LEVEL, 8'h00)
    pls(11'h008);
    `CHK(ERR_COUNT, 4'h0)
    `CHK(SRQ, 1'b0)
    pls(11'h001);
    `CHK(SRQ, 1'b1)
    $display("test 3 done");
    wr(3'h4, 8'h30);
    rd(SSRP_RD_IST, 16'h0001);
    for (int j = 0; j < 8; j++) begin
      exp_q.push_back({8'h00, j[0] ? ~(8'h01 << j) : 8'hff});
      @(posedge CLK_SYS);
      PPC_LINE <= 3'(j);
      PPC_SENSE <= j[0];
      PPC_WR <= 1'b1;
      @(posedge CLK_SYS);
      PPC_WR <= 1'b0;
      pv <= 11'h400;
      @(posedge CLK_SYS);
      pv <= 11'h000;
      @(negedge CLK_SYS);
    end
    pls(11'h048);
    rd(SSRP_RD_IST, 16'h0000);
    $display("test 4 done");
    @(posedge CLK_SYS);
    EVT_WR_DATA <= 16'h0001;
    EVT_ENA_WR <= 3'h1;
    @(posedge CLK_SYS);
    EVT_ENA_WR <= 3'h0;
    wr(3'h1, 8'h80);
    @(posedge CLK_SYS);
    COND_IN <= 48'h1;
    repeat (3) @(negedge CLK_SYS);
    `CHK(SRQ, 1'b1)
    rd(SSRP_RD_EVT, 16'h0001);
    rd(SSRP_RD_EVT, 16'h0000);
    `CHK(SRQ, 1'b0)
    $display("test 5 done");
    c[0] = 16'($urandom);
    @(posedge CLK_SYS);
    COND_IN <= {c[0], 32'h0000_0001};
    RD_IDX <= 2'h2;
    rd(SSRP_RD_COND, c[0]);
    rd(SSRP_RD_EVT, c[0]);
    rd(SSRP_RD_EVT, 16'h0000);
    @(posedge CLK_SYS);
    RD_IDX <= 2'h3;
    rd(SSRP_RD_COND, 16'h0000);
    `CHK(SRQ, 1'b0)
    $display("test 6 done");
    // Let the last answer be compared before the verdict.
    repeat (2) @(negedge CLK_SYS);
    end_of_test();
  end
endmodule
